// File: common/ffm_pkg.sv
// shared constants and types for the flash fault and monitor logic
`default_nettype none
package ffm_pkg;
  // clock and times, times in ns as specified
  localparam int CLK_NS      = 40;     // 25 MHz master clock
  localparam int RAMP_DG_NS  = 8000;   // ramp monitor persistence
  localparam int OVP_DG_NS   = 2000;   // open led persistence
  localparam int LONG_DG_NS  = 250000; // short led, thermal, input monitor
  localparam int STEP_NS     = 32000;  // ramp step period
  localparam int TICK_NS     = 250000; // converter delay unit
  // cycle counts: least times round up, periods round down
  localparam int RAMP_DG_CYC = (RAMP_DG_NS + CLK_NS - 1) / CLK_NS;
  localparam int OVP_DG_CYC  = (OVP_DG_NS + CLK_NS - 1) / CLK_NS;
  localparam int LONG_DG_CYC = (LONG_DG_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CYC    = STEP_NS / CLK_NS;
  localparam int TICK_CYC    = TICK_NS / CLK_NS;
  localparam int FIRST_HALT_CODE = 3;  // earliest code a halt may take
  localparam int PIN_W       = 14;     // synchronised pin bundle width
  // register offsets
  localparam logic [7:0] ADDR_INMON  = 8'h10;
  localparam logic [7:0] ADDR_HALTED = 8'h20;
  localparam logic [7:0] ADDR_LEDMON = 8'h30;
  localparam logic [7:0] ADDR_DELAY  = 8'h40;
  localparam logic [7:0] ADDR_FLAGS  = 8'h50;
  // input monitor config fields
  localparam int INMON_EN_BIT  = 0;
  localparam int VIN_THR_LSB   = 1;
  localparam int RAMP_EN_BIT   = 3;
  localparam int RAMP_THR_LSB  = 4;
  // led voltage monitor fields
  localparam int LM_MAN_BIT    = 4;
  localparam int LM_OFF_BIT    = 5;
  localparam int LM_EOC_BIT    = 6;
  // fault flag positions
  localparam int FLG_TO   = 0;
  localparam int FLG_TSD  = 1;
  localparam int FLG_LED  = 2;
  localparam int FLG_RF1  = 3;
  localparam int FLG_RF2  = 4;
  localparam int FLG_NTC  = 5;
  localparam int FLG_RAMP = 6;
  localparam int FLG_VIN  = 7;
  // reset values
  localparam logic [7:0] INMON_RST = 8'h00;
  localparam logic [7:0] DELAY_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic       EOC_RST   = 1'b1;
  // flash ramp sequence states, gray along idle, ramp, hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RAMP = 2'b01,
    ST_HOLD = 2'b11
  } ffm_state_t;
endpackage
`default_nettype wire

// File: common/ffm_adc_if.sv
// link between the supervisor and the converter delay sequencer
`default_nettype none
interface ffm_adc_if;
  logic       start; // conversion-done fell, restart delay
  logic       tick;  // one pulse per delay unit
  logic [4:0] delay; // delay code, n gives n+1 units
  logic       done;  // delay elapsed, take the sample
  modport seq (input start, input tick, input delay, output done);
  modport ctl (output start, output tick, output delay, input done);
endinterface
`default_nettype wire

// File: verilog/ffm_deglitch.sv
// persistence filter: output rises after raw stays high cnt cycles
`default_nettype none
module ffm_deglitch
#(
  parameter logic [15:0] CNT = 16'h0001
)
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic raw,
  output var  logic filt
);
  logic [15:0] cnt_q, cnt_d; // consecutive high cycles
  logic        filt_q, filt_d;

  // count while high, any low restarts
  always_comb
  begin
    cnt_d  = cnt_q;
    filt_d = filt_q;
    if (!raw)
    begin
      cnt_d  = 16'h0000;
      filt_d = 1'b0;
    end
    else if (cnt_q >= 16'(CNT - 16'h0001))
      filt_d = 1'b1;
    else
      cnt_d = cnt_q + 16'h0001;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q  <= 16'h0000;
      filt_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      filt_q <= filt_d;
    end
  end

  assign filt = filt_q;

  // a short pulse never gets through
  property p_dg_drop;
    @(posedge mclk) disable iff (!nrst)
    !raw |=> !filt;
  endproperty
  a_dg_drop: assert property (p_dg_drop) else $error("filter passed a glitch");
endmodule // ffm_deglitch
`default_nettype wire

// File: verilog/ffm_adc_seq.sv
// converter sample delay: counts delay units after conversion-done falls
`default_nettype none
module ffm_adc_seq
(
  input  wire logic mclk,
  input  wire logic nrst,
  ffm_adc_if.seq    adc
);
  logic [5:0] cnt_q, cnt_d;   // units left
  logic       busy_q, busy_d; // delay running
  logic       done_q, done_d;

  // load on start, count down on each unit tick
  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (adc.start)
    begin
      busy_d = 1'b1;
      cnt_d  = {1'b0, adc.delay} + 6'h01;
    end
    else if (busy_q && adc.tick)
    begin
      if (cnt_q == 6'h01)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      else
        cnt_d = cnt_q - 6'h01;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q  <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign adc.done = done_q;

  // the sample only follows a unit tick
  property p_done_tick;
    @(posedge mclk) disable iff (!nrst)
    done_q |-> $past(adc.tick) && !$past(adc.start);
  endproperty
  a_done_tick: assert property (p_done_tick) else $error("sample without delay");
endmodule // ffm_adc_seq
`default_nettype wire

// File: verilog/ffm_flash_supervisor.sv
// flash ramp monitor, halted code latch, led voltage converter control, fault flags
`default_nettype none
module ffm_flash_supervisor
#(
  parameter logic [15:0] LONG_DG_CYC_P = 16'(ffm_pkg::LONG_DG_CYC),
  parameter logic [15:0] TICK_CYC_P    = 16'(ffm_pkg::TICK_CYC)
)
(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       hardware_enable_pin,
  input  wire logic       strobe_pin,
  input  wire logic       ramp_cmp_low,
  input  wire logic       vin_cmp_low,
  input  wire logic       thermal_hot,
  input  wire logic       overvoltage_trip,
  input  wire logic       led_short_low,
  input  wire logic       ntc_low,
  input  wire logic       rf_sync_input_one,
  input  wire logic       rf_sync_input_two,
  input  wire logic [3:0] adc_code,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       flash_req,
  input  wire logic       enable_off,
  input  wire logic       level_edge,
  input  wire logic       timeout_expired,
  input  wire logic       torch_active,
  input  wire logic       privacy_active,
  input  wire logic       ntc_mode,
  input  wire logic [1:0] sync_mode,
  input  wire logic [1:0] sync_pol,
  input  wire logic [3:0] led1_target,
  input  wire logic [3:0] led2_target,
  output var  logic [7:0] reg_rdata,
  output var  logic       flash_on,
  output var  logic [3:0] led1_code,
  output var  logic [3:0] led2_code,
  output var  logic       sources_off,
  output var  logic       ramp_halted,
  output var  logic       ntc_limit,
  output var  logic       vin_limit,
  output var  logic [7:0] input_monitor_config,
  output var  logic       adc_shutdown,
  output var  logic       adc_sample
);
  import ffm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PIN_W-1:0] pin_raw, meta_q, sync_q; // two stages per pin
  logic             hardware_enable_pin_s, strobe_s, ramp_s, vin_s, therm_s, ovp_s, short_s, ntc_s;
  logic [1:0]       rf_s;
  logic [3:0]       adc_s;

  assign pin_raw = {adc_code, rf_sync_input_two, rf_sync_input_one, ntc_low,
                    led_short_low, overvoltage_trip, thermal_hot, vin_cmp_low,
                    ramp_cmp_low, strobe_pin, hardware_enable_pin};

  // only the second stage is read
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  assign {adc_s, rf_s, ntc_s, short_s, ovp_s, therm_s, vin_s, ramp_s, strobe_s, hardware_enable_pin_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // persistence filters: short led, open led, thermal, input monitor, ramp
  ffm_state_t  st_q, st_d;         // flash sequence state
  logic [7:0]  inmon_q, inmon_d;   // input monitor config
  logic        active;             // any current mode on
  logic [4:0]  dg_raw, dg_f;
  localparam logic [15:0] DG_CNT [5] = '{LONG_DG_CYC_P, 16'(OVP_DG_CYC),
                                         LONG_DG_CYC_P, LONG_DG_CYC_P,
                                         16'(RAMP_DG_CYC)};

  assign active = (st_q != ST_IDLE) || torch_active || privacy_active;
  assign dg_raw = {ramp_s && inmon_q[RAMP_EN_BIT] && st_q == ST_RAMP,
                   vin_s && inmon_q[INMON_EN_BIT],
                   therm_s,
                   ovp_s && active,
                   short_s && active};

  generate
    for (genvar i = 0; i < 5; i++)
    begin : g_dg
      ffm_deglitch #(.CNT(DG_CNT[i])) u_dg
      (
        .mclk (mclk),
        .nrst (nrst),
        .raw  (dg_raw[i]),
        .filt (dg_f[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // flash ramp sequence
  logic [3:0]  step_q, step_d;     // current ramp code
  logic [15:0] sdiv_q, sdiv_d;     // 32 us step divider
  logic [3:0]  code1_q, code1_d, code2_q, code2_d;
  logic        on_q, on_d;
  logic        strobe_prev_q;
  logic        ramp_halt_q, ramp_halt_d;
  logic [3:0]  hstep_q, hstep_d;   // code of last halt
  logic        sources_off_q, sources_off_d;
  logic [3:0]  maxt, cap;
  logic        halt_ev, end_ev, reached;

  assign maxt    = (led1_target > led2_target) ? led1_target : led2_target;
  assign cap     = (ramp_halt_q && hstep_q < maxt) ? hstep_q : maxt;
  // halt only from code three, only while ramping
  assign halt_ev = st_q == ST_RAMP && dg_f[4]
                   && step_q >= 4'(FIRST_HALT_CODE);
  assign reached = st_q == ST_RAMP && !halt_ev && step_q >= cap;
  // flash end: timeout, strobe fall in level mode, enable 00, thermal
  assign end_ev  = st_q != ST_IDLE && (timeout_expired || enable_off || dg_f[2]
                   || (strobe_prev_q && !strobe_s && !level_edge));

  // next ramp state and channel codes
  always_comb
  begin
    st_d   = st_q;
    step_d = step_q;
    sdiv_d = sdiv_q + 16'h0001;
    case (st_q)
      ST_IDLE:
      begin
        sdiv_d = 16'h0000;
        if (flash_req && !sources_off_q)
        begin
          st_d   = ST_RAMP;
          step_d = 4'h1;
        end
      end
      ST_RAMP:
      begin
        if (halt_ev || reached)
          st_d = ST_HOLD;
        else if (sdiv_q == 16'(STEP_CYC - 1))
        begin
          sdiv_d = 16'h0000;
          step_d = step_q + 4'h1;
        end
      end
      ST_HOLD:
        sdiv_d = 16'h0000;
      default:
        st_d = ST_IDLE;
    endcase
    if (end_ev || !hardware_enable_pin_s)
    begin
      st_d   = ST_IDLE;
      step_d = 4'h0;
    end
    on_d    = st_d != ST_IDLE;
    code1_d = (step_d < led1_target) ? step_d : led1_target;
    code2_d = (step_d < led2_target) ? step_d : led2_target;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q          <= ST_IDLE;
      step_q        <= 4'h0;
      sdiv_q        <= 16'h0000;
      on_q          <= 1'b0;
      code1_q       <= 4'h0;
      code2_q       <= 4'h0;
      strobe_prev_q <= 1'b0;
    end
    else
    begin
      st_q          <= st_d;
      step_q        <= step_d;
      sdiv_q        <= sdiv_d;
      on_q          <= on_d;
      code1_q       <= code1_d;
      code2_q       <= code2_d;
      strobe_prev_q <= strobe_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault flags and recovery latches
  logic [7:0] flags_q, flags_d, flag_set, halted_q, halted_d;
  logic [1:0] rf_prev_q, rf_ev;
  logic       flags_rd, ntc_lim_q, ntc_lim_d, vin_lim_q, vin_lim_d;

  assign flags_rd = reg_rd && reg_addr == ADDR_FLAGS;
  // polarity 1 picks rising, 0 falling
  assign rf_ev = (rf_s & ~rf_prev_q & sync_pol) | (~rf_s & rf_prev_q & ~sync_pol);

  always_comb
  begin
    flag_set           = 8'h00;
    flag_set[FLG_TO]   = st_q != ST_IDLE && timeout_expired;
    flag_set[FLG_TSD]  = dg_f[2];
    flag_set[FLG_LED]  = dg_f[0] || dg_f[1];
    flag_set[FLG_RF1]  = sync_mode[0] && rf_ev[0];
    flag_set[FLG_RF2]  = sync_mode[1] && rf_ev[1];
    flag_set[FLG_NTC]  = (on_q || torch_active) && ntc_mode && ntc_s;
    flag_set[FLG_RAMP] = halt_ev;
    flag_set[FLG_VIN]  = dg_f[3];
    // read clears, a same-cycle event wins; a lasting led fault re-sets
    flags_d       = (flags_rd ? FLAGS_RST : flags_q) | flag_set;
    sources_off_d = (sources_off_q && !flags_rd) || dg_f[2];
    ntc_lim_d     = (ntc_lim_q && !(flags_rd && !ntc_s)) || flag_set[FLG_NTC];
    vin_lim_d     = (vin_lim_q && !(flags_rd && !vin_s)) || dg_f[3];
    ramp_halt_d   = (ramp_halt_q && !flags_rd) || halt_ev;
    hstep_d       = halt_ev ? step_q : hstep_q;
    halted_d      = halt_ev ? {code2_q, code1_q} : halted_q;
    if (!hardware_enable_pin_s)
    begin
      flags_d       = FLAGS_RST;
      sources_off_d = 1'b0;
      ntc_lim_d     = 1'b0;
      vin_lim_d     = 1'b0;
      ramp_halt_d   = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_q       <= FLAGS_RST;
      sources_off_q <= 1'b0;
      ntc_lim_q     <= 1'b0;
      vin_lim_q     <= 1'b0;
      ramp_halt_q   <= 1'b0;
      hstep_q       <= 4'h0;
      halted_q      <= 8'h00;
      rf_prev_q     <= 2'b00;
    end
    else
    begin
      flags_q       <= flags_d;
      sources_off_q <= sources_off_d;
      ntc_lim_q     <= ntc_lim_d;
      vin_lim_q     <= vin_lim_d;
      ramp_halt_q   <= ramp_halt_d;
      hstep_q       <= hstep_d;
      halted_q      <= halted_d;
      rf_prev_q     <= rf_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, converter control and read data
  ffm_adc_if   adc_bus ();
  logic [7:0]  delay_q, delay_d, rdata_q, rdata_d;
  logic [3:0]  result_q, result_d;
  logic [15:0] tdiv_q, tdiv_d;     // 250 us unit divider
  logic        man_q, man_d, off_q, off_d, eoc_q, eoc_d, sample_q;
  logic        wr_lm, rd_lm, adc_start;

  assign wr_lm     = reg_wr && reg_addr == ADDR_LEDMON;
  assign rd_lm     = reg_rd && reg_addr == ADDR_LEDMON;
  assign adc_start = !off_q && ((man_q && rd_lm)
                     || (wr_lm && reg_wdata[LM_MAN_BIT])
                     || (!man_q && reached));
  assign adc_bus.start = adc_start;
  assign adc_bus.delay = delay_q[4:0];
  assign adc_bus.tick  = tdiv_q == 16'(TICK_CYC_P - 16'h0001);

  ffm_adc_seq u_seq
  (
    .mclk (mclk),
    .nrst (nrst),
    .adc  (adc_bus.seq)
  );

  // register writes, conversion flag, result capture, read mux
  always_comb
  begin
    inmon_d  = (reg_wr && reg_addr == ADDR_INMON) ? reg_wdata : inmon_q;
    delay_d  = (reg_wr && reg_addr == ADDR_DELAY) ? reg_wdata : delay_q;
    man_d    = wr_lm ? reg_wdata[LM_MAN_BIT] : man_q;
    off_d    = wr_lm ? reg_wdata[LM_OFF_BIT] : off_q;
    tdiv_d   = (adc_start || adc_bus.tick) ? 16'h0000 : tdiv_q + 16'h0001;
    eoc_d    = adc_start ? 1'b0 : (adc_bus.done || eoc_q);
    result_d = adc_bus.done ? adc_s : result_q;
    rdata_d  = rdata_q;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_INMON:  rdata_d = inmon_q;
        ADDR_HALTED: rdata_d = halted_q;
        ADDR_LEDMON: rdata_d = {1'b0, eoc_q, off_q, man_q, result_q};
        ADDR_DELAY:  rdata_d = delay_q;
        ADDR_FLAGS:  rdata_d = flags_q;
        default:     rdata_d = 8'h00;
      endcase
    end
    if (!hardware_enable_pin_s)
    begin
      inmon_d = INMON_RST;
      delay_d = DELAY_RST;
      man_d   = 1'b0;
      off_d   = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      inmon_q  <= INMON_RST;
      delay_q  <= DELAY_RST;
      man_q    <= 1'b0;
      off_q    <= 1'b0;
      eoc_q    <= EOC_RST;
      result_q <= 4'h0;
      tdiv_q   <= 16'h0000;
      rdata_q  <= 8'h00;
      sample_q <= 1'b0;
    end
    else
    begin
      inmon_q  <= inmon_d;
      delay_q  <= delay_d;
      man_q    <= man_d;
      off_q    <= off_d;
      eoc_q    <= eoc_d;
      result_q <= result_d;
      tdiv_q   <= tdiv_d;
      rdata_q  <= rdata_d;
      sample_q <= adc_bus.done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign reg_rdata            = rdata_q;
  assign flash_on             = on_q;
  assign led1_code            = code1_q;
  assign led2_code            = code2_q;
  assign sources_off          = sources_off_q;
  assign ramp_halted          = ramp_halt_q;
  assign ntc_limit            = ntc_lim_q;
  assign vin_limit            = vin_lim_q;
  assign input_monitor_config = inmon_q;
  assign adc_shutdown         = off_q;
  assign adc_sample           = sample_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_rd_clear;
    flags_rd && flag_set == 8'h00 && hardware_enable_pin_s |=> flags_q == 8'h00;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared by read");

  property p_set_wins;
    flags_rd && flag_set[FLG_RAMP] && hardware_enable_pin_s |=> flags_q[FLG_RAMP];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_halt_code;
    $rose(flags_q[FLG_RAMP]) |-> $past(st_q) == ST_RAMP && $past(step_q) >= 4'h3;
  endproperty
  a_halt_code: assert property (p_halt_code) else $error("halt too early");

  property p_freeze;
    halt_ev && !end_ev && hardware_enable_pin_s |=> st_q == ST_HOLD ##1 (st_q != ST_HOLD || $stable(step_q));
  endproperty
  a_freeze: assert property (p_freeze) else $error("ramp kept rising");

  property p_latch;
    halt_ev |=> halted_q == {$past(code2_q), $past(code1_q)};
  endproperty
  a_latch: assert property (p_latch) else $error("halted codes wrong");

  property p_tsd_block;
    sources_off_q && st_q == ST_IDLE |=> st_q == ST_IDLE;
  endproperty
  a_tsd_block: assert property (p_tsd_block) else $error("restart after thermal");

  property p_manual_eoc;
    !off_q && man_q && rd_lm |=> !eoc_q;
  endproperty
  a_manual_eoc: assert property (p_manual_eoc) else $error("done not cleared");

  property p_step;
    st_q == ST_RAMP && !halt_ev && !reached && !end_ev && hardware_enable_pin_s
      && sdiv_q == 16'(STEP_CYC - 1) |=> step_q == $past(step_q) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("step not advanced");

  property p_led_hold;
    flags_q[FLG_LED] && flags_rd && (dg_f[0] || dg_f[1]) && hardware_enable_pin_s |=> flags_q[FLG_LED];
  endproperty
  a_led_hold: assert property (p_led_hold) else $error("led flag cleared early");
endmodule // ffm_flash_supervisor
`default_nettype wire

// File: verification/ffm_host_model.sv
// host model: drives the register strobes one access at a time
`default_nettype none
module ffm_host_model
(
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // one-cycle strobe; read data is taken at the edge after it
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge mclk) #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk) #1;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d; // stale data never looks valid
  endtask
endmodule // ffm_host_model
`default_nettype wire

// File: verification/test_ffm_flash_supervisor.sv
// self-checking bench for the flash supervisor
`default_nettype none
module test_ffm_flash_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  import ffm_pkg::*;
  logic        mclk, nrst, hardware_enable_pin, strobe_pin, ramp_cmp_low, vin_cmp_low;
  logic        thermal_hot, overvoltage_trip, led_short_low, ntc_low, rf_sync_input_one;
  logic        rf_sync_input_two, reg_wr, reg_rd, flash_req, enable_off, level_edge;
  logic        timeout_expired, torch_active, privacy_active, ntc_mode, flash_on;
  logic        sources_off, ramp_halted, ntc_limit, vin_limit, adc_shutdown, adc_sample;
  logic [1:0]  sync_mode, sync_pol;
  logic [3:0]  adc_code, led1_target, led2_target, led1_code, led2_code;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, input_monitor_config, q;
  int          failures, tests_run, n, m;
  logic [31:0] seed = 32'hb1f8f1c5;
  // short filters and delay units keep the run brief
  ffm_flash_supervisor #(.LONG_DG_CYC_P(16'h0014), .TICK_CYC_P(16'h0010)) uut
  (
    .mclk, .nrst, .hardware_enable_pin, .strobe_pin, .ramp_cmp_low, .vin_cmp_low,
    .thermal_hot, .overvoltage_trip, .led_short_low, .ntc_low, .rf_sync_input_one,
    .rf_sync_input_two, .adc_code, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .flash_req,
    .enable_off, .level_edge, .timeout_expired, .torch_active, .privacy_active, .ntc_mode,
    .sync_mode, .sync_pol, .led1_target, .led2_target, .reg_rdata, .flash_on, .led1_code,
    .led2_code, .sources_off, .ramp_halted, .ntc_limit, .vin_limit, .input_monitor_config,
    .adc_shutdown, .adc_sample
  );
  ffm_host_model host (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    return $unsigned($random(seed));
  endfunction
  // per-channel code at a ramp step
  function automatic logic [7:0] step_codes(input logic [3:0] s, t1, t2);
    return {(t2 < s) ? t2 : s, (t1 < s) ? t1 : s};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.access(1'b0, a, 8'h00, q);
    check(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog: whole sequence needs well under 20000 cycles
  initial
  begin
    #(CLK_NS * 20000);
    failures++;
    complete_run();
  end
  initial
  begin
    {nrst, hardware_enable_pin, strobe_pin, ramp_cmp_low, vin_cmp_low, thermal_hot} = '0;
    {overvoltage_trip, led_short_low, ntc_low, rf_sync_input_one, rf_sync_input_two} = '0;
    {flash_req, enable_off, level_edge, timeout_expired, torch_active} = '0;
    {privacy_active, ntc_mode, sync_mode, sync_pol, adc_code, led1_target, led2_target} = '0;
    tick(5);
    nrst = 1'b1;
    hardware_enable_pin = 1'b1;
    tick(3);
    rd(ADDR_INMON, INMON_RST);
    rd(ADDR_DELAY, DELAY_RST);
    rd(ADDR_FLAGS, FLAGS_RST);
    rd(ADDR_LEDMON, 8'h40);
    rd(8'h60, 8'h00);
    // ramp monitor on, random threshold
    q = (8'(rnd()) & 8'h30) | 8'h08;
    n = q;
    wr(ADDR_INMON, q);
    rd(ADDR_INMON, 8'(n));
    check(input_monitor_config, 8'(n));
    // comparator low from the start: halt must wait for code three
    led1_target = 4'(4 + rnd() % 12);
    led2_target = 4'(4 + rnd() % 12);
    ramp_cmp_low = 1'b1;
    flash_req = 1'b1;
    tick(1);
    flash_req = 1'b0;
    check({led2_code, led1_code}, 8'h11);
    check(8'(flash_on), 8'h01);
    tick(999);
    check({led2_code, led1_code}, step_codes(4'h2, led1_target, led2_target));
    tick(1500);
    check({led2_code, led1_code}, step_codes(4'h3, led1_target, led2_target));
    check(8'(ramp_halted), 8'h01);
    ramp_cmp_low = 1'b0;
    rd(ADDR_HALTED, step_codes(4'h3, led1_target, led2_target));
    rd(ADDR_FLAGS, 8'h40);
    rd(ADDR_FLAGS, 8'h00);
    timeout_expired = 1'b1;
    tick(1);
    timeout_expired = 1'b0;
    tick(2);
    check(8'(led1_code), 8'h00);
    rd(ADDR_FLAGS, 8'h01);
    // manual conversion with a random delay code
    n = rnd() % 4;
    adc_code = 4'(rnd());
    wr(ADDR_DELAY, 8'(n));
    wr(ADDR_LEDMON, 8'h10);
    check(8'(adc_shutdown), 8'h00);
    for (m = 0; m < 300 && adc_sample !== 1'b1; m++)
      tick(1);
    check(8'(m >= (n + 1) * 16 && m <= (n + 1) * 16 + 3), 8'h01);
    rd(ADDR_LEDMON, {4'h5, adc_code});
    // rising edges count on input one only
    sync_mode = 2'b01;
    sync_pol = 2'b01;
    tick(3);
    rf_sync_input_one = 1'b1;
    rf_sync_input_two = 1'b1;
    tick(4);
    rd(ADDR_FLAGS, 8'h08);
    rf_sync_input_one = 1'b0;
    tick(4);
    rd(ADDR_FLAGS, 8'h00);
    // strobe fall ends a flash in level mode only; enable 00 always does
    strobe_pin = 1'b1;
    tick(3);
    for (m = 0; m < 2; m++)
    begin
      level_edge = (m == 0);
      flash_req = 1'b1;
      tick(1);
      flash_req = 1'b0;
      strobe_pin = 1'b0;
      tick(4);
      check(8'(flash_on), 8'(m == 0));
      enable_off = 1'b1;
      strobe_pin = 1'b1;
      tick(1);
      enable_off = 1'b0;
      tick(1);
      check(8'(flash_on), 8'h00);
    end
    rd(ADDR_FLAGS, 8'h00);
    // thermal trip ends the flash and refuses restarts until a flags read
    flash_req = 1'b1;
    thermal_hot = 1'b1;
    tick(1);
    flash_req = 1'b0;
    tick(25);
    check({6'h00, sources_off, flash_on}, 8'h02);
    thermal_hot = 1'b0;
    flash_req = 1'b1;
    tick(4);
    check({6'h00, sources_off, flash_on}, 8'h02);
    rd(ADDR_FLAGS, 8'h02);
    tick(1);
    check({6'h00, sources_off, flash_on}, 8'h01);
    flash_req = 1'b0;
    enable_off = 1'b1;
    tick(1);
    enable_off = 1'b0;
    // open led, thermistor and input monitor faults; recovery needs a read with fault gone
    wr(ADDR_INMON, 8'h01);
    {torch_active, ntc_mode, overvoltage_trip, ntc_low, vin_cmp_low} = 5'h1f;
    tick(60);
    check({6'h00, ntc_limit, vin_limit}, 8'h03);
    rd(ADDR_FLAGS, 8'ha4);
    {overvoltage_trip, ntc_low, vin_cmp_low} = 3'h0;
    tick(4);
    check({6'h00, ntc_limit, vin_limit}, 8'h03);
    rd(ADDR_FLAGS, 8'ha4);
    check({6'h00, ntc_limit, vin_limit}, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    {torch_active, ntc_mode} = 2'h0;
    // automatic mode: the ramp reaching its target starts the conversion
    wr(ADDR_LEDMON, 8'h00);
    led1_target = 4'h2;
    led2_target = 4'h1;
    flash_req = 1'b1;
    tick(1);
    flash_req = 1'b0;
    tick(803);
    check({led2_code, led1_code}, step_codes(4'h2, led1_target, led2_target));
    rd(ADDR_LEDMON, {4'h0, adc_code});
    adc_code = ~adc_code;
    tick(80);
    rd(ADDR_LEDMON, {4'h4, adc_code});
    enable_off = 1'b1;
    tick(1);
    enable_off = 1'b0;
    // converter off: neither a manual rewrite nor a read starts it
    wr(ADDR_LEDMON, 8'h20);
    check(8'(adc_shutdown), 8'h01);
    wr(ADDR_LEDMON, 8'h30);
    rd(ADDR_LEDMON, {4'h7, adc_code});
    complete_run();
  end
endmodule // test_ffm_flash_supervisor
`default_nettype wire
